// ### rtl/lvds_pixel_packetizer.sv
`timescale 1ns/1ps
`include "pix_pkt_regs.svh"
module lvds_pixel_packetizer #(
  parameter int BIT_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // pixel stream, sampled on rising edges of the pixel clock
  input wire logic pix_clk_i,
  input wire logic [9:0] master_pix_i,
  input wire logic [9:0] slave_pix_i,
  input wire logic line_active_i,
  input wire logic frame_active_i,
  input wire logic slave_line_active_i,
  input wire logic slave_frame_active_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // lvds pairs as single-ended level plus enable
  output logic serial_data_pair_o,
  output logic serial_data_pair_oe_o,
  output logic shift_clock_pair_o,
  output logic shift_clock_pair_oe_o,
  output logic sync_fault_o
);
  if (BIT_DIV < 1 || BIT_DIV > 255) begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  // decoded field by field: the struct packs its fields in another order than the register
  localparam logic [31:0] CTRL_INIT = `CTRL_RESET;

  // ==========================================
  // state
  typedef struct packed {
    logic [1:0] pc_sync;
    logic [21:0] pix_s1;
    logic [21:0] pix_s2;
    logic [1:0] slv_s1;
    logic [1:0] slv_s2;
    logic pc_prev;
    pix_pkt_pkg::pix_word_t cur;
    logic prev_line;
    logic prev_frame;
    logic [9:0] hist1;
    logic [9:0] hist2;
    logic [9:0] pend_m;
    logic [9:0] pend_s;
    logic pend_v;
    logic [1:0] rep_left;
    logic [17:0] pkt;
    logic [4:0] pkt_len;
    logic load;
    logic [7:0] div;
    logic bit_en;
    pix_pkt_pkg::ctrl_t ctrl;
    logic sync_err;
    logic [31:0] pix_cnt;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic sd_out;
    logic sd_oe;
    logic sc_out;
    logic sc_oe;
    logic fault;
  } top_q_t;

  top_q_t q;
  top_q_t next_q;
  logic ser_busy;
  logic ser_data;
  logic ser_clk;

  pkt_serializer #(
    .W(18)
  ) u_ser (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .bit_en_i(q.bit_en),
    .load_i(q.load),
    .pkt_i(q.pkt),
    .len_i(q.pkt_len),
    .busy_o(ser_busy),
    .sdata_o(ser_data),
    .sclk_o(ser_clk)
  );

  // collision substitution, both single words and the reserved run
  function automatic logic [9:0] scrub(input logic [9:0] v, input logic [9:0] h1,
                                       input logic [9:0] h2);
    logic [9:0] r;
    r = v;
    if (v <= `WORD_FRAME_OFF) begin
      r = `WORD_SUBST; // R08
    end
    // R18 falls out of R08: the middle zero of 1023,0,1023 is already 4
    if (h2 == `WORD_MAX && h1 == `WORD_FRAME_ON && v == `WORD_MAX) begin
      r = `WORD_MAX; // R18
    end
    return r;
  endfunction

  function automatic logic [17:0] build(input pix_pkt_pkg::ctrl_t c, input logic [9:0] m,
                                        input logic [9:0] s, input logic lv,
                                        input logic fv);
    logic [17:0] p;
    p = '0;
    if (c.stereo) begin
      p = {1'b0, s[9:2], m[9:2], 1'b1}; // R04 R05
    end else if (c.wide_pixel_select_bit) begin
      p = {6'h00, 1'b0, m, 1'b1}; // R01 R03
    end else begin
      p = {6'h00, 1'b0, fv, lv, m[9:2], 1'b1}; // R01 R02
    end
    return p;
  endfunction

  logic pc_rise;
  logic [2:0] rep_cnt;
  logic [9:0] sm;
  logic [9:0] ss;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;

  always_comb begin
    next_q = q;
    next_q.load = 1'b0;
    pc_rise = 1'b0;
    rep_cnt = 3'h1;
    sm = '0;
    ss = '0;
    wmask = '0;
    ctrl_word = '0;

    // ========================================
    // synchronisers for the pixel domain
    next_q.pc_sync = {q.pc_sync[0], pix_clk_i};
    next_q.pix_s1 = {master_pix_i, slave_pix_i, line_active_i, frame_active_i};
    next_q.pix_s2 = q.pix_s1;
    next_q.slv_s1 = {slave_line_active_i, slave_frame_active_i};
    next_q.slv_s2 = q.slv_s1;
    next_q.pc_prev = q.pc_sync[1];
    pc_rise = q.pc_sync[1] && !q.pc_prev;

    // ========================================
    // bit-rate divider
    next_q.bit_en = 1'b0;
    if (q.div == 8'(BIT_DIV - 1)) begin
      next_q.div = '0;
      next_q.bit_en = 1'b1;
    end else begin
      next_q.div = q.div + 8'h01;
    end

    case (q.ctrl.column_bin_factor)
      2'b01: rep_cnt = 3'h2; // R11
      2'b10, 2'b11: rep_cnt = 3'h4; // R12
      default: rep_cnt = 3'h1;
    endcase

    // ========================================
    // capture a pixel, decide which word goes out
    if (pc_rise) begin
      next_q.cur = q.pix_s2;
      next_q.prev_line = q.pix_s2[1];
      next_q.prev_frame = q.pix_s2[0];
      sm = q.pix_s2[21:12];
      ss = q.pix_s2[11:2];
      if (q.pix_s2[0] && !q.prev_frame) begin
        sm = `WORD_FRAME_ON; // R06
        ss = `WORD_FRAME_ON;
      end else if (!q.pix_s2[0] && q.prev_frame) begin
        sm = `WORD_FRAME_OFF; // R06
        ss = `WORD_FRAME_OFF;
      end else if (q.pix_s2[1] && !q.prev_line) begin
        sm = `WORD_LINE_ON; // R07
        ss = `WORD_LINE_ON;
      end else if (!q.pix_s2[1] && q.prev_line) begin
        sm = `WORD_LINE_OFF; // R07
        ss = `WORD_LINE_OFF;
      end else begin
        sm = scrub(q.pix_s2[21:12], q.hist1, q.hist2);
        ss = scrub(q.pix_s2[11:2], q.hist1, q.hist2);
      end
      next_q.hist1 = q.pix_s2[21:12];
      next_q.hist2 = q.hist1;
      next_q.pend_m = sm;
      next_q.pend_s = ss;
      next_q.pend_v = 1'b1;
      next_q.rep_left = 2'(rep_cnt - 3'h1); // R10
      next_q.pix_cnt = q.pix_cnt + 32'h1;
      if (q.ctrl.stereo && (q.pix_s2[1:0] != q.slv_s2)) begin
        next_q.sync_err = 1'b1; // R19
      end
    end

    // ========================================
    // hand packets to the serializer; a late pixel overrides stale repeats
    if (!ser_busy && !q.load && q.pend_v) begin
      next_q.pkt = build(q.ctrl, q.pend_m, q.pend_s, q.cur.line_active,
                         q.cur.frame_active);
      next_q.pkt_len = q.ctrl.stereo ? `PKT_LEN_ST : `PKT_LEN_SA; // R10
      next_q.load = 1'b1;
      if (q.rep_left == 2'h0) begin
        next_q.pend_v = pc_rise;
      end else if (!pc_rise) begin
        next_q.rep_left = q.rep_left - 2'h1; // R11 R12
      end
    end

    // ========================================
    // axi4-lite slave
    next_q.awready = !q.aw_hold && !q.bvalid && !q.awready;
    next_q.wready = !q.w_hold && !q.bvalid && !q.wready;
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_hold = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
      next_q.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_hold = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
      next_q.wready = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{q.w_strb[i]}};
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      next_q.aw_hold = 1'b0;
      next_q.w_hold = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = `RESP_OKAY;
      if (q.aw_addr == `REG_CTRL) begin
        ctrl_word = {25'h0, q.ctrl.column_bin_factor, q.ctrl.shift_clock_powerdown,
                     q.ctrl.serial_data_powerdown, q.ctrl.serial_block_powerdown,
                     q.ctrl.stereo, q.ctrl.wide_pixel_select_bit};
        ctrl_word = (ctrl_word & ~wmask) | (q.w_data & wmask);
        next_q.ctrl.wide_pixel_select_bit = ctrl_word[`CTRL_WIDE];
        next_q.ctrl.stereo = ctrl_word[`CTRL_STEREO];
        next_q.ctrl.serial_block_powerdown = ctrl_word[`CTRL_BLK_PD];
        next_q.ctrl.serial_data_powerdown = ctrl_word[`CTRL_DATA_PD];
        next_q.ctrl.shift_clock_powerdown = ctrl_word[`CTRL_SCLK_PD];
        next_q.ctrl.column_bin_factor = ctrl_word[`CTRL_BIN_HI:`CTRL_BIN_LO];
      end else if (q.aw_addr == `REG_STAT) begin
        // write one to clear; a fresh fault in the same cycle wins
        if (q.w_strb[0] && q.w_data[`STAT_SYNC_ERR] && !next_q.sync_err) begin
          next_q.sync_err = 1'b0;
        end else if (q.w_strb[0] && q.w_data[`STAT_SYNC_ERR] && !(pc_rise && q.ctrl.stereo
                     && (q.pix_s2[1:0] != q.slv_s2))) begin
          next_q.sync_err = 1'b0;
        end
      end else if (q.aw_addr != `REG_PIX) begin
        next_q.bresp = `RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    next_q.arready = !q.rvalid && !q.arready;
    if (s_axi_arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = `RESP_OKAY;
      if (s_axi_araddr == `REG_CTRL) begin
        next_q.rdata = {25'h0, q.ctrl.column_bin_factor, q.ctrl.shift_clock_powerdown,
                        q.ctrl.serial_data_powerdown, q.ctrl.serial_block_powerdown,
                        q.ctrl.stereo, q.ctrl.wide_pixel_select_bit};
      end else if (s_axi_araddr == `REG_STAT) begin
        next_q.rdata = {30'h0, q.sync_err, ser_busy};
      end else if (s_axi_araddr == `REG_PIX) begin
        next_q.rdata = q.pix_cnt;
      end else begin
        next_q.rdata = '0;
        next_q.rresp = `RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // ========================================
    // pin drive
    next_q.sd_out = ser_data;
    next_q.sc_out = ser_clk;
    next_q.sd_oe = !q.ctrl.serial_block_powerdown; // R14
    next_q.sc_oe = !q.ctrl.serial_block_powerdown && !q.ctrl.shift_clock_powerdown; // R15
    next_q.fault = q.ctrl.stereo && q.sync_err; // R16 R19
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.ctrl.wide_pixel_select_bit <= CTRL_INIT[`CTRL_WIDE];
      q.ctrl.stereo <= CTRL_INIT[`CTRL_STEREO];
      q.ctrl.serial_block_powerdown <= CTRL_INIT[`CTRL_BLK_PD]; // R17
      q.ctrl.serial_data_powerdown <= CTRL_INIT[`CTRL_DATA_PD];
      q.ctrl.shift_clock_powerdown <= CTRL_INIT[`CTRL_SCLK_PD];
      q.ctrl.column_bin_factor <= CTRL_INIT[`CTRL_BIN_HI:`CTRL_BIN_LO];
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign serial_data_pair_o = q.sd_out;
  assign serial_data_pair_oe_o = q.sd_oe;
  assign shift_clock_pair_o = q.sc_out;
  assign shift_clock_pair_oe_o = q.sc_oe;
  assign sync_fault_o = q.fault;
endmodule

// ### rtl/pix_pkt_regs.svh
`ifndef PIX_PKT_REGS_SVH
`define PIX_PKT_REGS_SVH
// ==========================================
// How it works
// R01: standalone packet 12 bits, start one, stop zero
// R02: narrow mode: pixel[9:2], line, frame bits
// R03: wide mode: pixel[9:0], no sync bits
// R04: stereo packet 18 bits, start, stop
// R05: stereo: master byte then slave byte
// R06: word 0 before frame, 3 after
// R07: word 1 before line, 2 after
// R08: real pixels 0..3 become 4
// R09: receiver rebuilds line/frame from flag words
// R10: binning keeps packet length, repeats pixels
// R11: bin two sends each pixel twice
// R12: bin four sends each pixel four times
// R13: receiver keeps one of 2 or 4
// R14: data pair tristate when block powered down
// R15: clock pair driven only both bits clear
// R16: fault output low outside stereo mode
// R17: host powers block down when unused
// R18: run 1023,0,1023 sent as 1023,4,1023
// R19: stereo fault flag on master/slave desync
// R20: serialize bit 0 first, one packet per pixel; with binning on, the code sends each pixel 2 or 4 times
// ==========================================
// register map
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_PIX 8'h08
`define CTRL_WIDE 0
`define CTRL_STEREO 1
`define CTRL_BLK_PD 2
`define CTRL_DATA_PD 3
`define CTRL_SCLK_PD 4
`define CTRL_BIN_LO 5
`define CTRL_BIN_HI 6
`define CTRL_RESET 32'h0000_0004
`define STAT_BUSY 0
`define STAT_SYNC_ERR 1
`define STAT_SYNC_ERR_CLR 32'h0000_0002
// ==========================================
// packet and flag words
`define PKT_LEN_SA 5'h0c
`define PKT_LEN_ST 5'h12
`define WORD_FRAME_ON 10'h000
`define WORD_LINE_ON 10'h001
`define WORD_LINE_OFF 10'h002
`define WORD_FRAME_OFF 10'h003
`define WORD_SUBST 10'h004
`define WORD_MAX 10'h3ff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rtl/pix_pkt_pkg.sv
package pix_pkt_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b10
  } ser_state_t;

  typedef struct packed {
    logic [9:0] master;
    logic [9:0] slave;
    logic line_active;
    logic frame_active;
  } pix_word_t;

  typedef struct packed {
    logic wide_pixel_select_bit;
    logic stereo;
    logic serial_block_powerdown;
    logic serial_data_powerdown;
    logic shift_clock_powerdown;
    logic [1:0] column_bin_factor;
  } ctrl_t;
endpackage

// ### rtl/pkt_serializer.sv
`timescale 1ns/1ps
`include "pix_pkt_regs.svh"
// shifts one packet out, bit 0 first, one bit per two bit-enable pulses (clock rise, then fall)
module pkt_serializer #(
  parameter int W = 18
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic bit_en_i,
  input wire logic load_i,
  input wire logic [W-1:0] pkt_i,
  input wire logic [4:0] len_i,
  output logic busy_o,
  output logic sdata_o,
  output logic sclk_o
);
  if (W < 18) begin : g_narrow
    $error("serializer too narrow for stereo packets");
  end

  typedef struct packed {
    logic [W-1:0] sh;
    logic [4:0] left;
    logic busy;
    logic sdata;
    logic sclk;
  } ser_q_t;

  ser_q_t q;
  ser_q_t next_q;

  always_comb begin
    next_q = q;
    if (load_i && !q.busy) begin
      next_q.sh = pkt_i;
      next_q.left = len_i;
      next_q.busy = 1'b1;
    end else if (q.busy && bit_en_i) begin
      if (!q.sclk) begin
        next_q.sdata = q.sh[0]; // R20
        next_q.sclk = 1'b1;
      end else begin
        next_q.sclk = 1'b0;
        next_q.sh = q.sh >> 1;
        next_q.left = q.left - 5'h01;
        if (q.left == 5'h01) begin
          next_q.busy = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign busy_o = q.busy;
  assign sdata_o = q.sdata;
  assign sclk_o = q.sclk;
endmodule

// ### verif/lvds_pixel_packetizer_sva.sv
`timescale 1ns/1ps
// =====
// port checks: serial framing and register bus
module pix_pkt_chk #(
  parameter int BIT_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic serial_data_pair_o,
  input wire logic serial_data_pair_oe_o,
  input wire logic shift_clock_pair_o,
  input wire logic shift_clock_pair_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire sck = shift_clock_pair_o;
  wire sdo = serial_data_pair_o;
  // level run lengths; a low run longer than a bit marks the gap between packets
  int hi_cnt;
  int lo_cnt;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hi_cnt <= 0;
      lo_cnt <= 0;
    end else begin
      hi_cnt <= sck ? hi_cnt + 1 : 0;
      lo_cnt <= sck ? 0 : lo_cnt + 1;
    end
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence pkt_begin;
    $rose(sck) && lo_cnt > 2 * BIT_DIV;
  endsequence
  sequence pkt_gap;
    lo_cnt == 3 * BIT_DIV && !sck;
  endsequence
  AST_CLK_NEEDS_DATA: assert property (shift_clock_pair_oe_o |-> serial_data_pair_oe_o)
    else $error("shift clock driven with data pair off");
  AST_START_BIT: assert property (pkt_begin |-> sdo)
    else $error("packet without start bit");
  AST_STOP_BIT: assert property (pkt_gap |-> !sdo)
    else $error("packet without stop bit");
  AST_DATA_EDGE: assert property ($changed(sdo) |-> $rose(sck))
    else $error("data moved off the shift clock rise");
  AST_SCLK_HIGH: assert property ($fell(sck) |-> hi_cnt == BIT_DIV)
    else $error("shift clock high phase wrong");
  AST_B_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_AW_DROP: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stayed up");
endmodule

bind lvds_pixel_packetizer pix_pkt_chk #(.BIT_DIV(BIT_DIV)) chk_u (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .serial_data_pair_o(serial_data_pair_o), .serial_data_pair_oe_o(serial_data_pair_oe_o),
  .shift_clock_pair_o(shift_clock_pair_o), .shift_clock_pair_oe_o(shift_clock_pair_oe_o)
);

// ### verif/lvds_rx_model.sv
`timescale 1ns/1ps
// =====
// far-end deserializer
module lvds_rx_model (
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic [4:0] len_i,
  input wire logic [2:0] keep_i,
  output logic [17:0] word_o,
  output logic [17:0] kept_o,
  output int count_o,
  output logic line_o,
  output logic frame_o
);
  logic [17:0] sh = '0;
  int n = 0;
  int slot = 0;
  initial begin
    count_o = 0;
    line_o = 0;
    frame_o = 0;
  end
  // sample at the fall: data moves on the rise, so mid-bit is safest
  always @(negedge sclk_i) begin
    if (n == 0)
      sh = '0;
    if (n > 0 || sdata_i === 1'b1) begin
      sh[n] = sdata_i;
      n++;
    end
    if (n == int'(len_i)) begin
      n = 0;
      word_o = sh;
      count_o++;
      if (slot == 0)
        kept_o = sh;
      slot = (slot + 1) % int'(keep_i);
      // only meaningful in wide mode, where the full word is visible
      case (sh[10:1])
        10'h000: frame_o = 1'b1;
        10'h001: line_o = 1'b1;
        10'h002: line_o = 1'b0;
        10'h003: frame_o = 1'b0;
        default: ;
      endcase
    end
  end
endmodule

// ### verif/lvds_pixel_packetizer_tb.sv
`timescale 1ns/1ps
`include "pix_pkt_regs.svh"
module lvds_pixel_packetizer_tb;
  logic ref_clk_i = 0, rstn_i = 0, pix_clk_i = 0, lv = 0, fv = 0, desync = 0;
  logic [9:0] mp = 10'h0, sp = 10'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sd, sd_oe, sc, sc_oe, fault;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] rx_len = 5'h0c;
  logic [2:0] rx_keep = 3'h1;
  logic [17:0] rx_word, rx_kept;
  logic rx_line, rx_frame;
  int rx_cnt, failures = 0, check_count = 0, cyc = 0;
  lvds_pixel_packetizer #(.BIT_DIV(1)) dut_u (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pix_clk_i(pix_clk_i), .master_pix_i(mp),
    .slave_pix_i(sp), .line_active_i(lv), .frame_active_i(fv),
    .slave_line_active_i(lv ^ desync), .slave_frame_active_i(fv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_data_pair_o(sd), .serial_data_pair_oe_o(sd_oe), .shift_clock_pair_o(sc),
    .shift_clock_pair_oe_o(sc_oe), .sync_fault_o(fault));
  lvds_rx_model rx_u (.sclk_i(sc_oe ? sc : 1'b0), .sdata_i(sd_oe ? sd : 1'bz),
    .len_i(rx_len), .keep_i(rx_keep), .word_o(rx_word), .kept_o(rx_kept),
    .count_o(rx_cnt), .line_o(rx_line), .frame_o(rx_frame));
  always #20 ref_clk_i = ~ref_clk_i;
  // =====
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("ERROR %0t: run hung", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 0;
    logic w = 0;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge ref_clk_i);
      if (awready) aw = 1;
      if (wready) w = 1;
      if (aw) awvalid <= 0;
      if (w) wvalid <= 0;
    end while (!(aw && w));
    while (bvalid !== 1'b1) @(posedge ref_clk_i);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge ref_clk_i); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge ref_clk_i);
    rd_val = rdata;
    resp = rresp;
    rready <= 0;
  endtask
  // one pixel clock pulse, then wait for the packets it should cause
  task automatic px(input logic [9:0] m, input logic [9:0] s, input logic [1:0] sy, input int n);
    int c0 = rx_cnt;
    @(posedge ref_clk_i);
    mp <= m;
    sp <= s;
    fv <= sy[1];
    lv <= sy[0];
    @(posedge ref_clk_i);
    pix_clk_i <= 1;
    repeat (4) @(posedge ref_clk_i);
    pix_clk_i <= 0;
    while (rx_cnt < c0 + n) @(posedge ref_clk_i);
    repeat (60) @(posedge ref_clk_i);
    chk(rx_cnt - c0, n);
  endtask
  // =====
  // scenarios
  task automatic t_reset();
    chk({sd_oe, sc_oe, fault}, 3'h0);
    rd(`REG_CTRL);
    chk(rd_val, `CTRL_RESET);
    rd(`REG_STAT);
    chk(rd_val, 32'h0);
    rd(8'h40);
    chk(resp, `RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(resp, `RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_power();
    for (int i = 0; i < 8; i++) begin
      wr(`REG_CTRL, 32'(i) << 2);
      repeat (3) @(posedge ref_clk_i);
      chk(sd_oe, !i[0]);
      chk(sc_oe, !(i[0] | i[2]));
    end
    $display("power test done");
  endtask
  task automatic t_wide();
    logic [1:0] sy [9] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h0};
    logic [9:0] pv [9] = '{10'h155, 10'h155, 10'h155, 10'h002, 10'h3ff,
                           10'h000, 10'h3ff, 10'h155, 10'h155};
    logic [9:0] ev [9] = '{10'h000, 10'h001, 10'h155, 10'h004, 10'h3ff,
                           10'h004, 10'h3ff, 10'h002, 10'h003};
    wr(`REG_CTRL, 32'h1);
    for (int k = 0; k < 9; k++) begin
      px(pv[k], 10'h0, sy[k], 1);
      chk(rx_word, {1'b0, ev[k], 1'b1});
      chk({rx_frame, rx_line}, sy[k]);
    end
    $display("wide test done");
  endtask
  task automatic t_narrow();
    wr(`REG_CTRL, 32'h0);
    px(10'h100, 10'h0, 2'h2, 1);
    px(10'h2a5, 10'h0, 2'h2, 1);
    chk(rx_word, {1'b0, 1'b1, 1'b0, 8'ha9, 1'b1});
    px(10'h100, 10'h0, 2'h0, 1);
    $display("narrow test done");
  endtask
  task automatic t_stereo();
    wr(`REG_CTRL, 32'h2);
    rx_len = 5'h12;
    px(10'h0, 10'h0, 2'h2, 1);
    px(10'h3f0, 10'h10c, 2'h2, 1);
    chk(rx_word, {1'b0, 8'h43, 8'hfc, 1'b1});
    chk(fault, 1'b0);
    desync <= 1;
    px(10'h3f0, 10'h10c, 2'h2, 1);
    chk(fault, 1'b1);
    rd(`REG_STAT);
    chk(rd_val[1], 1'b1);
    desync <= 0;
    wr(`REG_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    chk(fault, 1'b0);
    wr(`REG_STAT, `STAT_SYNC_ERR_CLR);
    wr(`REG_CTRL, 32'h2);
    repeat (3) @(posedge ref_clk_i);
    chk(fault, 1'b0);
    px(10'h0, 10'h0, 2'h0, 1);
    $display("stereo test done");
  endtask
  task automatic t_bin();
    logic [11:0] e;
    rx_len = 5'h0c;
    wr(`REG_CTRL, 32'h1);
    px(10'h0, 10'h0, 2'h2, 1);
    for (int b = 1; b < 4; b++) begin
      e = {1'b0, 10'h2c7 + 10'(b), 1'b1};
      rx_keep = (b == 1) ? 3'h2 : 3'h4;
      wr(`REG_CTRL, 32'h1 | (32'(b) << 5));
      px(e[10:1], 10'h0, 2'h2, int'(rx_keep));
      chk(rx_kept, e);
      chk(rx_word, e);
    end
    rx_keep = 3'h1;
    wr(`REG_CTRL, 32'h1);
    px(10'h0, 10'h0, 2'h0, 1);
    // pixel counter is read-only: the write must not disturb the 21 pulses sent so far
    wr(`REG_PIX, 32'h0);
    chk(resp, `RESP_OKAY);
    rd(`REG_PIX);
    chk(rd_val, 32'h15);
    $display("binning test done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1;
    @(posedge ref_clk_i);
    t_reset();
    t_power();
    t_wide();
    t_narrow();
    t_stereo();
    t_bin();
    wr(`REG_CTRL, `CTRL_RESET);
    tally_and_finish();
  end
endmodule
